// *** hw/eur_rx.sv ***
// extended serial receive data path with register access over axi4-lite
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "eur_consts.svh"
// Behaviour
// - enabled receiver takes over receive pin
// - synchronous mode samples on transfer clock
// - receive complete flag as standard port
// - level mode: frame, overrun, parity flags
// - biphase mode: overrun and biphase frame error
// - error flags held until low read
// - parity only for level encoded data
// - overrun when buffer full loses character
// - up to eight bits: low register only
// - ninth bit in extension bit zero
// - unused extension bits read as zero
// - low byte write starts transmission
// - seventeenth bit in ninth-bit position
// - transmit size field decoding
// - receive size decoding, automatic 16/17 in biphase mode only
// - biphase error: flag, complete, restart
// - valid 17th transition gives long frame
module eur_rx (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // serial line
  input  wire logic        RXD,
  input  wire logic        TRANSFER_CLOCK_PIN,
  output logic             RXD_OVERRIDE,
  output logic             RX_COMPLETE,
  // transmit hand-off
  output logic             TX_START,
  output logic [16:0]      TX_DATA
);
  // ==========================================================
  // bus and register state
  logic              aw_v_q, aw_v_d, w_v_q, w_v_d, b_v_q, b_v_d, r_v_q, r_v_d;
  logic [7:0]        aw_a_q, aw_a_d;
  logic [7:0]        w_b0_q, w_b0_d, w_b1_q, w_b1_d;
  logic [1:0]        w_s_q, w_s_d, b_r_q, b_r_d, r_r_q, r_r_d;
  logic [31:0]       r_d_q, r_d_d;
  logic [7:0]        csize_q, csize_d, ctlb_q, ctlb_d, txlo_q, txlo_d, txhi_q, txhi_d;
  logic [15:0]       baud_q, baud_d;
  logic              txs_q, txs_d;
  logic [16:0]       txd_q, txd_d;
  logic              do_wr, rd_pop, mapped_w, mapped_r;
  logic [7:0]        rd_val;

  function automatic logic is_reg(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `EUR_OFS_BAUD);
  endfunction

  // ==========================================================
  // receiver state
  eur_pkg::eur_state_t st_q, st_d;
  eur_pkg::eur_char_t  buf_q, buf_d, dc;
  logic [15:0]       cnt_q, cnt_d;
  logic [4:0]        bitn_q, bitn_d, n, idx;
  logic [16:0]       sh_q, sh_d;
  logic              rxd_q, xck_q, h1v_q, h1v_d, par_q, par_d, fe_q, fe_d, upe_q, upe_d;
  logic              lng_q, lng_d, stopn_q, stopn_d, rxc_q, rxc_d, dor_q, dor_d;
  logic [1:0]        stp_q, stp_d;
  logic              receive_enable_bit, sync, biph, autob, xck_rise, h1, h2, smp, done, biphase_frame_error;

  assign receive_enable_bit     = ctlb_q[`EUR_CB_RECEIVE_ENABLE_BIT];
  assign sync     = ctlb_q[`EUR_CB_SYNC];
  assign biph     = ctlb_q[`EUR_CB_BIPH];
  assign n        = eur_pkg::eur_size(csize_q[3:0]);
  assign autob    = biph && (csize_q[3:0] == `EUR_SZ_AUTO);
  assign xck_rise = TRANSFER_CLOCK_PIN && !xck_q;
  assign h1       = biph && (cnt_q == (baud_q >> 2));
  assign h2       = biph && (cnt_q == baud_q - (baud_q >> 2));
  assign smp      = biph ? h2 : (sync ? xck_rise : (cnt_q == (baud_q >> 1)));
  assign idx      = ctlb_q[`EUR_CB_MSB] ? 5'(n - 5'h01 - bitn_q) : bitn_q;

  // ==========================================================
  // bus slave
  always_comb begin
    aw_v_d = aw_v_q;
    aw_a_d = aw_a_q;
    w_v_d  = w_v_q;
    w_b0_d = w_b0_q;
    w_b1_d = w_b1_q;
    w_s_d  = w_s_q;
    b_v_d  = b_v_q && !S_AXI_BREADY;
    b_r_d  = b_r_q;
    r_v_d  = r_v_q && !S_AXI_RREADY;
    r_r_d  = r_r_q;
    r_d_d  = r_d_q;
    csize_d = csize_q;
    ctlb_d = ctlb_q;
    baud_d = baud_q;
    txlo_d = txlo_q;
    txhi_d = txhi_q;
    txs_d  = 1'b0;
    txd_d  = txd_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_v_d = 1'b1;
      aw_a_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_v_d  = 1'b1;
      w_b0_d = S_AXI_WDATA[7:0];
      w_b1_d = S_AXI_WDATA[15:8];
      w_s_d  = S_AXI_WSTRB[1:0];
    end
    do_wr    = aw_v_q && w_v_q && !b_v_q;
    mapped_w = is_reg(aw_a_q);
    if (do_wr) begin
      aw_v_d = 1'b0;
      w_v_d  = 1'b0;
      b_v_d  = 1'b1;
      b_r_d  = mapped_w ? `EUR_RSP_OK : `EUR_RSP_SLV;
      if (w_s_q[0]) begin
        unique case (aw_a_q)
          `EUR_OFS_DHIGH: txhi_d = w_b0_q;
          `EUR_OFS_CSIZE: csize_d = w_b0_q;
          `EUR_OFS_CTLB:  ctlb_d = w_b0_q;
          `EUR_OFS_BAUD:  baud_d[7:0] = w_b0_q;
          `EUR_OFS_DLOW: begin
            txlo_d = w_b0_q;
            txs_d  = 1'b1;
            txd_d  = {ctlb_q[`EUR_CB_TX9], txhi_q, w_b0_q}
                     & 17'((18'h00001 << eur_pkg::eur_size(csize_q[7:4])) - 18'h00001);
          end
          default: ;
        endcase
      end
      if (w_s_q[1] && aw_a_q == `EUR_OFS_BAUD) baud_d[15:8] = w_b1_q;
    end
    mapped_r = is_reg(S_AXI_ARADDR);
    rd_pop   = S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == `EUR_OFS_DLOW);
    unique case (S_AXI_ARADDR)
      `EUR_OFS_DLOW:  rd_val = buf_q.data[7:0];
      `EUR_OFS_DHIGH: rd_val = buf_q.data[15:8];
      `EUR_OFS_CSIZE: rd_val = csize_q;
      `EUR_OFS_CTLB:  rd_val = ctlb_q;
      `EUR_OFS_STA:   rd_val = {rxc_q, 2'b00, buf_q.fe, dor_q, buf_q.parity_error_flag, buf_q.data[16], 1'b0};
      `EUR_OFS_STC:   rd_val = {4'h0, buf_q.biphase_frame_error, buf_q.lng, buf_q.stp};
      `EUR_OFS_BAUD:  rd_val = baud_q[7:0];
      default:        rd_val = 8'h00;
    endcase
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_v_d = 1'b1;
      r_r_d = mapped_r ? `EUR_RSP_OK : `EUR_RSP_SLV;
      r_d_d = (S_AXI_ARADDR == `EUR_OFS_BAUD) ? {16'h0000, baud_q} : {24'h000000, rd_val};
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      {aw_v_q, w_v_q, b_v_q, r_v_q, txs_q} <= 5'h00;
      {aw_a_q, w_b0_q, w_b1_q, txlo_q, txhi_q} <= 40'h0000000000;
      {w_s_q, b_r_q, r_r_q} <= 6'h00;
      r_d_q   <= 32'h00000000;
      csize_q <= `EUR_CSIZE_RST;
      ctlb_q  <= `EUR_CTLB_RST;
      baud_q  <= `EUR_BAUD_RST;
      txd_q   <= 17'h00000;
    end else begin
      {aw_v_q, w_v_q, b_v_q, r_v_q, txs_q} <= {aw_v_d, w_v_d, b_v_d, r_v_d, txs_d};
      {aw_a_q, w_b0_q, w_b1_q, txlo_q, txhi_q} <= {aw_a_d, w_b0_d, w_b1_d, txlo_d, txhi_d};
      {w_s_q, b_r_q, r_r_q} <= {w_s_d, b_r_d, r_r_d};
      r_d_q   <= r_d_d;
      csize_q <= csize_d;
      ctlb_q  <= ctlb_d;
      baud_q  <= baud_d;
      txd_q   <= txd_d;
    end
  end

  assign S_AXI_AWREADY = !aw_v_q;
  assign S_AXI_WREADY  = !w_v_q;
  assign S_AXI_BVALID  = b_v_q;
  assign S_AXI_BRESP   = b_r_q;
  assign S_AXI_ARREADY = !r_v_q;
  assign S_AXI_RVALID  = r_v_q;
  assign S_AXI_RRESP   = r_r_q;
  assign S_AXI_RDATA   = r_d_q;
  assign RXD_OVERRIDE  = receive_enable_bit;
  assign RX_COMPLETE   = rxc_q;
  assign TX_START      = txs_q;
  assign TX_DATA       = txd_q;

  // ==========================================================
  // frame receiver
  always_comb begin
    st_d    = st_q;
    cnt_d   = (cnt_q >= 16'(baud_q - 16'h0001)) ? 16'h0000 : 16'(cnt_q + 16'h0001);
    bitn_d  = bitn_q;
    sh_d    = sh_q;
    h1v_d   = h1 ? RXD : h1v_q;
    par_d   = par_q;
    fe_d    = fe_q;
    upe_d   = upe_q;
    lng_d   = lng_q;
    stp_d   = stp_q;
    stopn_d = stopn_q;
    done    = 1'b0;
    biphase_frame_error     = 1'b0;
    unique case (st_q)
      eur_pkg::ST_IDLE: begin
        {cnt_d, bitn_d, sh_d} = 38'h0;
        {par_d, fe_d, upe_d, lng_d, stopn_d} = 5'h00;
        if (sync ? (xck_rise && !RXD) : (rxd_q && !RXD))
          st_d = sync ? eur_pkg::ST_DATA : eur_pkg::ST_START;
      end
      eur_pkg::ST_START: begin
        if (h1 && RXD) st_d = eur_pkg::ST_IDLE;
        else if (smp) st_d = (RXD == biph) ? eur_pkg::ST_DATA : eur_pkg::ST_IDLE;
      end
      eur_pkg::ST_DATA: if (smp) begin
        if (biph && h1v_q == RXD) begin
          done  = 1'b1;
          st_d  = eur_pkg::ST_IDLE;
          if (autob && bitn_q == 5'h10) stp_d = {stp_q[0], RXD};
          else biphase_frame_error = 1'b1;
        end else begin
          bitn_d = 5'(bitn_q + 5'h01);
          par_d  = par_q ^ RXD;
          if (autob && bitn_q == 5'h10) begin
            sh_d[16] = RXD;
            lng_d    = 1'b1;
            st_d     = eur_pkg::ST_STOP;
          end else begin
            sh_d[idx] = RXD;
            if (bitn_q == 5'(n - 5'h01) && !autob)
              st_d = (ctlb_q[`EUR_CB_PEN] && !biph) ? eur_pkg::ST_PAR : eur_pkg::ST_STOP;
          end
        end
      end
      eur_pkg::ST_PAR: if (smp) begin
        upe_d = par_q ^ RXD ^ ctlb_q[`EUR_CB_PODD];
        st_d  = eur_pkg::ST_STOP;
      end
      eur_pkg::ST_STOP: if (smp) begin
        if (biph) stp_d = {stp_q[0], RXD};
        else if (!stopn_q) fe_d = !RXD;
        if (biph && ctlb_q[`EUR_CB_STOP2] && !stopn_q) stopn_d = 1'b1;
        else begin
          done = 1'b1;
          st_d = eur_pkg::ST_IDLE;
        end
      end
    endcase
    if (!receive_enable_bit) begin
      st_d = eur_pkg::ST_IDLE;
      done = 1'b0;
    end
    dc = '{data: sh_d, fe: fe_d && !biph, parity_error_flag: upe_d && !biph, biphase_frame_error: biphase_frame_error, lng: lng_d, stp: stp_d};
    buf_d = buf_q;
    rxc_d = rxc_q;
    dor_d = dor_q;
    if (rd_pop) begin
      rxc_d = 1'b0;
      dor_d = 1'b0;
    end
    if (done) begin
      if (rxc_q && !rd_pop) dor_d = 1'b1;
      else begin
        buf_d = dc;
        rxc_d = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= eur_pkg::ST_IDLE;
      buf_q <= '0;
      {cnt_q, bitn_q, sh_q} <= 38'h0;
      {rxd_q, xck_q, h1v_q, par_q, fe_q, upe_q} <= 6'h20;
      {lng_q, stopn_q, rxc_q, dor_q, stp_q} <= 6'h00;
    end else begin
      st_q <= st_d;
      buf_q <= buf_d;
      {cnt_q, bitn_q, sh_q} <= {cnt_d, bitn_d, sh_d};
      {rxd_q, xck_q, h1v_q, par_q, fe_q, upe_q} <= {RXD, TRANSFER_CLOCK_PIN, h1v_d, par_d, fe_d, upe_d};
      {lng_q, stopn_q, rxc_q, dor_q, stp_q} <= {lng_d, stopn_d, rxc_d, dor_d, stp_d};
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_wr_dlow;
    do_wr && aw_a_q == `EUR_OFS_DLOW && w_s_q[0];
  endsequence
  sequence s_tx_go;
    TX_START ##1 !TX_START;
  endsequence
  property p_tx_start;
    s_wr_dlow |=> s_tx_go;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("low write did not start send");

  property p_pin;
    do_wr && aw_a_q == `EUR_OFS_CTLB && w_s_q[0] |=> RXD_OVERRIDE == $past(w_b0_q[0]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin ownership not following enable");

  property p_rxc;
    done && !rxc_q |=> rxc_q && buf_q == $past(dc);
  endproperty
  a_rxc: assert property (p_rxc) else $error("completed char not flagged");

  property p_pop;
    rd_pop && !done |=> !rxc_q && !dor_q;
  endproperty
  a_pop: assert property (p_pop) else $error("low read did not consume char");

  property p_hold;
    rxc_q && !rd_pop |=> rxc_q && buf_q.fe == $past(buf_q.fe) && buf_q.biphase_frame_error == $past(buf_q.biphase_frame_error);
  endproperty
  a_hold: assert property (p_hold) else $error("error flags changed before read");

  property p_dor;
    done && rxc_q && !rd_pop |=> dor_q && buf_q == $past(buf_q);
  endproperty
  a_dor: assert property (p_dor) else $error("overrun not flagged or char lost");

  property p_biph;
    done && biph |-> !dc.fe && !dc.parity_error_flag;
  endproperty
  a_biph: assert property (p_biph) else $error("level error flag in biphase");

  property p_fem;
    done && biphase_frame_error && !rxc_q |=> rxc_q && buf_q.biphase_frame_error && st_q == eur_pkg::ST_IDLE;
  endproperty
  a_fem: assert property (p_fem) else $error("biphase error handling wrong");

  property p_long;
    st_q == eur_pkg::ST_DATA && autob && bitn_q == 5'h10 && smp && h1v_q != RXD && receive_enable_bit
      |=> st_q == eur_pkg::ST_STOP && lng_q;
  endproperty
  a_long: assert property (p_long) else $error("long frame not detected");

  property p_sync;
    receive_enable_bit && sync && st_q == eur_pkg::ST_IDLE && !xck_rise |=> st_q == eur_pkg::ST_IDLE;
  endproperty
  a_sync: assert property (p_sync) else $error("sync start without clock edge");

  property p_narrow;
    done && !autob && n <= 5'h08 |-> dc.data[16:8] == 9'h000;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper bits set on narrow char");
endmodule // eur_rx
`default_nettype wire

// *** hw/eur_consts.svh ***
// offsets, field positions, reset values and codes of the receive data path
`ifndef EUR_CONSTS_SVH
`define EUR_CONSTS_SVH
`define EUR_OFS_DLOW  8'h00
`define EUR_OFS_DHIGH 8'h04
`define EUR_OFS_CSIZE 8'h08
`define EUR_OFS_STA   8'h0c
`define EUR_OFS_CTLB  8'h10
`define EUR_OFS_STC   8'h14
`define EUR_OFS_BAUD  8'h18
`define EUR_CSIZE_RST 8'h33
`define EUR_CTLB_RST  8'h00
`define EUR_BAUD_RST  16'h0000
`define EUR_CB_RECEIVE_ENABLE_BIT   0
`define EUR_CB_SYNC   1
`define EUR_CB_BIPH   2
`define EUR_CB_MSB    3
`define EUR_CB_PEN    4
`define EUR_CB_PODD   5
`define EUR_CB_STOP2  6
`define EUR_CB_TX9    7
`define EUR_SZ_9      4'h7
`define EUR_SZ_AUTO   4'he
`define EUR_SZ_17     4'hf
`define EUR_RSP_OK    2'b00
`define EUR_RSP_SLV   2'b10
`endif

// *** hw/eur_pkg.sv ***
// types and size decoding of the receive data path
`include "eur_consts.svh"
package eur_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_DATA  = 5'h04,
    ST_PAR   = 5'h08,
    ST_STOP  = 5'h10
  } eur_state_t;

  typedef struct packed {
    logic [16:0] data;
    logic        fe;
    logic        parity_error_flag;
    logic        biphase_frame_error;
    logic        lng;
    logic [1:0]  stp;
  } eur_char_t;

  // character size field to bit count, reserved codes give 8
  function automatic logic [4:0] eur_size(input logic [3:0] code);
    logic [4:0] n;
    n = 5'h08;
    if (code[3:2] == 2'b00) n = 5'h05 + {3'h0, code[1:0]};
    else if (code == `EUR_SZ_9) n = 5'h09;
    else if (code[3:2] == 2'b10) n = 5'h0d + {3'h0, code[1:0]};
    else if (code == `EUR_SZ_AUTO) n = 5'h10;
    else if (code == `EUR_SZ_17) n = 5'h11;
    return n;
  endfunction
endpackage

// *** test/eur_txm.sv ***
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module eur_txm (
  // clock
  input  wire logic        clk,
  // frame request
  input  wire logic        go,
  input  wire logic [19:0] frame,
  input  wire logic [4:0]  nfr,
  input  wire logic [15:0] bit_cyc,
  // serial line
  output logic             rxd,
  output logic             transfer_clock_pin,
  output var logic         busy
);
  // ==========
  // frame shifter
  logic [19:0] sh_q;
  logic [4:0]  left_q;
  logic [15:0] cnt_q;
  initial busy = 1'b0;
  // one frame bit per bit period, first bit first
  always @(posedge clk) begin
    if (!busy && go) begin
      sh_q   <= frame;
      left_q <= nfr;
      cnt_q  <= 16'h0001;
      busy   <= 1'b1;
    end else if (busy && cnt_q == bit_cyc) begin
      sh_q   <= sh_q >> 1;
      cnt_q  <= 16'h0001;
      left_q <= left_q - 5'h01;
      busy   <= (left_q != 5'h01);
    end else if (busy) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // idle line rests high
  assign rxd = busy ? sh_q[0] : 1'b1;
  // transfer clock rises mid-bit, rests low between frames
  assign transfer_clock_pin = busy && (cnt_q > (bit_cyc >> 1));
endmodule // eur_txm
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the receive data path
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int BAUD  = 16;
  localparam int LIMIT = 40000;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rxd, transfer_clock_pin, ovr, receive_complete_flag, txs, go, busy;
  logic [15:0] bcyc;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v, seed;
  logic [1:0]  bresp, rresp, r;
  logic [16:0] txdat, txd, d, d2;
  logic [19:0] frame;
  logic [4:0]  nfr;
  int          err_total, samples_checked, cyc, txn, n;
  logic [3:0]  rxcode [0:10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7,
                                 4'h8, 4'h9, 4'ha, 4'hb, 4'hf};
  logic [7:0]  ectl [0:2] = '{8'h11, 8'h11, 8'h01};
  logic [7:0]  est [0:2] = '{8'h80, 8'h84, 8'h90};
  logic [3:0]  txcode [0:2] = '{4'h7, 4'h8, 4'hf};

  eur_rx u_eur_rx (.REF_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RXD(rxd), .TRANSFER_CLOCK_PIN(transfer_clock_pin),
    .RXD_OVERRIDE(ovr), .RX_COMPLETE(receive_complete_flag), .TX_START(txs), .TX_DATA(txdat));
  eur_txm u_eur_txm (.clk(clk), .go(go), .frame(frame), .nfr(nfr),
    .bit_cyc(bcyc), .rxd(rxd), .transfer_clock_pin(transfer_clock_pin), .busy(busy));

  // ==========
  // clock, watchdog, transmit monitor
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      final_report;
    end
  end
  always @(negedge clk) begin
    if (txs === 1'b1) begin
      txn++;
      txd = txdat;
    end
  end

  // ==========
  // expectation helpers
  function automatic int nb(input logic [3:0] c);
    if (c[3:2] == 2'b00) return 5 + int'(c[1:0]);
    if (c == 4'h7) return 9;
    if (c[3:2] == 2'b10) return 13 + int'(c[1:0]);
    if (c == 4'hf) return 17;
    return 8;
  endfunction
  function automatic logic [16:0] msk(input logic [16:0] x, input int k);
    return x & ((17'h1 << k) - 17'h1);
  endfunction
  function automatic logic [19:0] mkf(input logic [16:0] x, input int k,
                                      input logic pe, input logic pb, input logic sb);
    logic [19:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < k; i++) f[i + 1] = x[i];
    if (pe) f[k + 1] = (^x) ^ pb;
    f[k + 1 + int'(pe)] = ~sb;
    return f;
  endfunction
  // biphase frame in half bits: start, eight data bits, one stop bit
  function automatic logic [19:0] mkb(input logic [7:0] x);
    logic [19:0] f;
    f = 20'hc0002;
    for (int i = 0; i < 8; i++) f[2 * i + 3 -: 2] = {x[i], ~x[i]};
    return f;
  endfunction

  // ==========
  // checks and bus cycles
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task pins(input logic [1:0] e);
    @(negedge clk);
    chk({30'h0, ovr, receive_complete_flag}, {30'h0, e});
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
    logic ta, tw, t;
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    bready <= 1'b1;
    do begin
      @(negedge clk);
      t = bvalid;
      rs = bresp;
      @(posedge clk);
    end while (!t);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = rvalid;
      x = rdata;
      rs = rresp;
      @(posedge clk);
    end while (!t);
    rready <= 1'b0;
  endtask
  task snd(input logic [19:0] f, input int k);
    int w;
    frame <= f;
    nfr <= 5'(k);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(negedge clk); while (busy);
    w = 0;
    while (receive_complete_flag !== 1'b1 && w < 64) begin
      @(negedge clk);
      w++;
    end
    chk(32'(receive_complete_flag), 32'h1);
    @(posedge clk);
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========
  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata, frame, nfr} = '0;
    {err_total, samples_checked, cyc, txn} = '0;
    seed = 32'h31ed;
    bcyc = 16'(BAUD);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h08, v, r);
    chk(v, 32'h33);
    pins(2'b00);
    rd(8'h40, v, r);
    chk(32'(r), 32'h2);
    wr(8'h40, 32'h0, r);
    chk(32'(r), 32'h2);
    wr(8'h18, BAUD, r);
    wr(8'h10, 32'h01, r);
    pins(2'b10);
    $display("test reset and enable done");
    foreach (rxcode[i]) begin
      n = nb(rxcode[i]);
      d = msk(17'($random(seed)), n);
      wr(8'h08, {24'h0, 4'h3, rxcode[i]}, r);
      rd(8'h08, v, r);
      chk(v, {24'h0, 4'h3, rxcode[i]});
      snd(mkf(d, n, 1'b0, 1'b0, 1'b0), n + 2);
      rd(8'h0c, v, r);
      chk(v, {24'h0, 6'h20, d[16], 1'b0});
      rd(8'h04, v, r);
      chk(v, {24'h0, d[15:8]});
      rd(8'h00, v, r);
      chk(v, {24'h0, d[7:0]});
      pins(2'b10);
    end
    $display("test character sizes done");
    wr(8'h08, 32'h33, r);
    foreach (ectl[i]) begin
      d = msk(17'($random(seed)), 8);
      wr(8'h10, {24'h0, ectl[i]}, r);
      snd(mkf(d, 8, ectl[i][4], i == 1, i == 2), 10 + int'(ectl[i][4]));
      rd(8'h0c, v, r);
      chk(v, {24'h0, est[i]});
      rd(8'h04, v, r);
      rd(8'h0c, v, r);
      chk(v, {24'h0, est[i]});
      rd(8'h00, v, r);
      chk(v, {24'h0, d[7:0]});
    end
    d = msk(17'($random(seed)), 8);
    d2 = msk(17'($random(seed)), 8);
    snd(mkf(d, 8, 1'b0, 1'b0, 1'b0), 10);
    snd(mkf(d2, 8, 1'b0, 1'b0, 1'b0), 10);
    rd(8'h0c, v, r);
    chk(v, 32'h88);
    rd(8'h00, v, r);
    chk(v, {24'h0, d[7:0]});
    rd(8'h0c, v, r);
    chk(v, 32'h0);
    $display("test error flags done");
    wr(8'h10, 32'h0b, r);
    d = msk(17'($random(seed)), 8);
    d2 = '0;
    for (int i = 0; i < 8; i++) d2[i] = d[7 - i];
    snd(mkf(d2, 8, 1'b0, 1'b0, 1'b0), 10);
    rd(8'h0c, v, r);
    chk(v, 32'h80);
    rd(8'h00, v, r);
    chk(v, {24'h0, d[7:0]});
    bcyc <= 16'h0008;
    wr(8'h10, 32'h05, r);
    d = msk(17'($random(seed)), 8);
    snd(mkb(d[7:0]), 20);
    rd(8'h0c, v, r);
    chk(v, 32'h80);
    rd(8'h14, v, r);
    chk(v & 32'h0c, 32'h0);
    rd(8'h00, v, r);
    chk(v, {24'h0, d[7:0]});
    snd(20'hffffe, 4);
    rd(8'h0c, v, r);
    chk(v, 32'h80);
    rd(8'h14, v, r);
    chk(v & 32'h0c, 32'h08);
    rd(8'h00, v, r);
    pins(2'b10);
    bcyc <= 16'(BAUD);
    $display("test sync and biphase done");
    foreach (txcode[i]) begin
      d2 = 17'($random(seed));
      d = msk(d2, nb(txcode[i]));
      wr(8'h08, {24'h0, txcode[i], 4'h3}, r);
      wr(8'h10, {24'h0, d2[16], 7'h01}, r);
      wr(8'h04, {24'h0, d2[15:8]}, r);
      chk(32'(txn), 32'h0);
      wr(8'h00, {24'h0, d2[7:0]}, r);
      repeat (4) @(posedge clk);
      chk(32'(txn), 32'h1);
      chk({15'h0, txd}, {15'h0, d});
      txn = 0;
    end
    $display("test transmit hand-off done");
    wr(8'h10, 32'h0, r);
    pins(2'b00);
    $display("test disable done");
    final_report;
  end
endmodule // testbench
`default_nettype wire
